// file: inc/jesd_cfg_pkg.sv
// Purpose: shared constants and helpers for the channel and sync-header configuration link
// Assumes: 9-bit samples from four channels, register port with 10-bit addresses
// Notes: device register offsets are the device's own; controller offsets are APB byte addresses
package jesd_cfg_pkg;
	// ------------------------------------------------------------
	// device register map
	// ------------------------------------------------------------
	localparam int DEV_ADDR_W = 10;
	localparam int DEV_DATA_W = 8;
	localparam logic [9:0] CHAN_EN_ADDR = 10'h209;
	localparam logic [2:0] CHAN_EN_RESET = 3'h3;
	localparam logic [9:0] SYNC_SEL_ADDR = 10'h20f;
	localparam logic [1:0] SYNC_SEL_RESET = 2'h0;
	localparam logic [9:0] LANE_INFO_ADDR = 10'h2f0;
	localparam int LOWER_BIT = 0;
	localparam int UPPER_BIT = 1;
	localparam int SINGLE_BIT = 2;
	localparam logic [1:0] SYNC_CRC = 2'h0;
	localparam logic [1:0] SYNC_FEC = 2'h2;
	// ------------------------------------------------------------
	// link word layout
	// ------------------------------------------------------------
	localparam int SAMPLE_W = 9;
	localparam int CHANNELS = 4;
	localparam int SLOT_W = SAMPLE_W * CHANNELS;
	localparam int SYNC_WORD_W = 32;
	localparam int FIFO_DEPTH = 8;
	localparam logic [1:0] HDR_NONE = 2'h0;
	localparam logic [1:0] HDR_CRC = 2'h1;
	localparam logic [1:0] HDR_FEC = 2'h2;
	localparam logic [25:0] CRC12_POLY = 26'h000080f;
	localparam logic [25:0] FEC_POLY = 26'h0220211;
	localparam logic [4:0] CRC12_TOP = 5'd11;
	localparam logic [4:0] FEC_TOP = 5'd25;
	localparam int MODE_W = 4;
	localparam int MODE_ENC66_BIT = 3;
	// ------------------------------------------------------------
	// controller APB map
	// ------------------------------------------------------------
	localparam int APB_ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CHAN_OFS = 8'h04;
	localparam logic [7:0] SYNC_OFS = 8'h08;
	localparam logic [7:0] INFO_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] LANE_LO_OFS = 8'h14;
	localparam logic [7:0] LANE_HI_OFS = 8'h18;
	localparam logic [7:0] SYNC_WORD_OFS = 8'h1c;
	localparam int LINK_EN_BIT = 0;
	localparam int CAL_EN_BIT = 1;
	localparam int MODE_LSB = 4;
	localparam int CAP_BIT = 0;
	localparam int REFUSED_BIT = 1;

	typedef logic [MODE_W-1:0] mode_t;

	// remainder of a bit-serial LFSR division, msb first; top is the degree minus one
	function automatic logic [25:0] lfsr_rem(input logic [SLOT_W-1:0] d,
		input logic [25:0] poly, input logic [4:0] top);
		logic [25:0] r;
		logic [25:0] mask;
		logic fb;
		r = 26'h0;
		mask = (26'h1 << (top + 5'd1)) - 26'h1;
		for (int i = SLOT_W - 1; i >= 0; i--) begin
			fb = d[i] ^ r[top];
			r = ((r << 1) & mask) ^ (fb ? poly : 26'h0);
		end
		return r;
	endfunction : lfsr_rem
endpackage : jesd_cfg_pkg

// file: inc/jesd_cfg_if.sv
// Purpose: carrier between the converter-side transmitter and its controller
// Assumes: one clock shared by both ends
// Notes: register port is request/acknowledge; lane words use valid/ready
`timescale 1ns/1ps
interface jesd_cfg_if;
	import jesd_cfg_pkg::*;
	logic reg_req;
	logic reg_write;
	logic [DEV_ADDR_W-1:0] reg_addr;
	logic [DEV_DATA_W-1:0] reg_wdata;
	logic reg_ack;
	logic [DEV_DATA_W-1:0] reg_rdata;
	logic link_enable;
	logic calib_enable;
	mode_t link_mode_select;
	logic lane_valid;
	logic lane_ready;
	logic [SLOT_W-1:0] lane_data;
	logic [3:0] lane_index;
	logic lane_tail;
	logic [1:0] header_kind;
	logic [SYNC_WORD_W-1:0] sync_word;

	modport device(input reg_req, reg_write, reg_addr, reg_wdata, link_enable, calib_enable,
		link_mode_select, lane_ready, output reg_ack, reg_rdata, lane_valid, lane_data,
		lane_index, lane_tail, header_kind, sync_word);
	modport controller(output reg_req, reg_write, reg_addr, reg_wdata, link_enable,
		calib_enable, link_mode_select, lane_ready, input reg_ack, reg_rdata, lane_valid,
		lane_data, lane_index, lane_tail, header_kind, sync_word);
endinterface : jesd_cfg_if

// file: design/sample_fifo.sv
// Purpose: first-in first-out buffer for sample words
// Assumes: DEPTH is a power of two
// Notes: out_data is read straight from the storage flops
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0] count;
	} fifo_state_s;
	fifo_state_s state_reg;
	fifo_state_s state_next;
	logic push;
	logic pop;

	assign in_ready = (state_reg.count != (PW + 1)'(DEPTH));
	assign out_valid = (state_reg.count != '0);
	assign out_data = state_reg.mem[state_reg.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.mem[state_reg.wr_ptr] = in_data;
			state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			state_next.count = state_reg.count + 1'b1;
		end else if (pop && !push) begin
			state_next.count = state_reg.count - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : sample_fifo

// file: design/jesd_cfg_device.sv
// Purpose: converter-side transmitter configuration: channel pairs, lane scaling, sync header
// Assumes: controller keeps link and calibration enables low while reconfiguring
// Notes: one lane word per lane per frame; every word carries the whole slot vector
//
// What this block does
// - single-channel mode keeps channels B, C, D off
// - software sets lower pair with single mode
// - upper pair bit enables channels C and D
// - lower pair bit enables channels A and B
// - software disables calibration and link before changes
// - software never disables every channel pair
// - one pair off halves lanes, converters
// - odd full lanes with pair off: tail bits
// - lower pair off: C, D take A, B slots
// - sync field: 0 sends CRC-12, 2 FEC
// - sync selection only in 64B/66B; 32 bits
// - command fields always zero, idle headers
// - sync selection changed only with link disabled
// - software writes reserved bits as zero
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module jesd_cfg_device #(
	parameter int FIFO_DEPTH = jesd_cfg_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic reset_n,
	jesd_cfg_if.device link,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic [jesd_cfg_pkg::SLOT_W-1:0] sample_data,
	output logic [jesd_cfg_pkg::CHANNELS-1:0] channel_power,
	output logic [3:0] lanes_active,
	output logic [2:0] converters_active
);
	import jesd_cfg_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_emit = 2'b01
	} frame_state_e;

	typedef struct packed {
		logic [2:0] chan_en;
		logic [1:0] sync_sel;
		frame_state_e state;
		logic [3:0] lane_cnt;
		logic [SLOT_W-1:0] slots;
		logic [SYNC_WORD_W-1:0] frame_sync;
		logic [1:0] frame_kind;
		logic out_valid;
		logic [SLOT_W-1:0] out_data;
		logic [3:0] out_index;
		logic out_tail;
		logic [1:0] out_kind;
		logic [SYNC_WORD_W-1:0] out_sync;
		logic ack;
		logic [DEV_DATA_W-1:0] rdata;
	} dev_state_s;

	dev_state_s state_reg;
	dev_state_s state_next;

	logic fifo_valid;
	logic fifo_ready;
	logic [SLOT_W-1:0] fifo_data;

	// ------------------------------------------------------------
	// sample buffer
	// ------------------------------------------------------------
	// back-pressure: a disabled link stops popping, so the source stalls once it fills
	sample_fifo #(
		.WIDTH(SLOT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data(sample_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	// ------------------------------------------------------------
	// channel and lane decode
	// ------------------------------------------------------------
	logic single;
	logic lower_on;
	logic upper_on;
	logic pair_off;
	logic [3:0] lanes_full;
	logic [3:0] lanes;
	logic [2:0] converters;
	logic tail_needed;
	logic enc66;
	logic [SLOT_W-1:0] mapped;
	logic [1:0] hdr_kind;
	logic [SYNC_WORD_W-1:0] sync_calc;

	assign single = state_reg.chan_en[SINGLE_BIT];
	assign lower_on = state_reg.chan_en[LOWER_BIT];
	assign upper_on = state_reg.chan_en[UPPER_BIT] && !single;
	assign channel_power[0] = lower_on;
	assign channel_power[1] = lower_on && !single;
	assign channel_power[2] = upper_on;
	assign channel_power[3] = upper_on;
	assign pair_off = !(lower_on && upper_on);
	// full-mode lane count comes from the low bits of the mode; four converters in full mode
	assign lanes_full = {1'b0, link.link_mode_select[2:0]} + 4'h1;
	assign lanes = pair_off ? ((lanes_full + 4'h1) >> 1) : lanes_full;
	assign converters = single ? 3'd1 : (pair_off ? 3'd2 : 3'd4);
	assign tail_needed = pair_off && lanes_full[0];
	assign enc66 = link.link_mode_select[MODE_ENC66_BIT];
	assign lanes_active = lanes;
	assign converters_active = converters;

	always_comb begin
		mapped = '0;
		if (single) begin
			mapped[SAMPLE_W-1:0] = fifo_data[SAMPLE_W-1:0];
		end else if (lower_on && upper_on) begin
			mapped = fifo_data;
		end else if (lower_on) begin
			mapped[2*SAMPLE_W-1:0] = fifo_data[2*SAMPLE_W-1:0];
		end else begin
			// C and D move down into the A and B slots
			mapped[2*SAMPLE_W-1:0] = fifo_data[SLOT_W-1:2*SAMPLE_W];
		end
	end

	// reserved selections fall back to CRC-12 rather than sending an undefined header
	always_comb begin
		hdr_kind = HDR_NONE;
		sync_calc = '0;
		if (enc66) begin
			if (state_reg.sync_sel == SYNC_FEC) begin
				hdr_kind = HDR_FEC;
				// upper command bits stay zero: idle headers only
				sync_calc = {6'h0, lfsr_rem(mapped, FEC_POLY, FEC_TOP)};
			end else begin
				hdr_kind = HDR_CRC;
				sync_calc = {20'h0, lfsr_rem(mapped, CRC12_POLY, CRC12_TOP)[11:0]};
			end
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign fifo_ready = (state_reg.state == st_idle) && link.link_enable;

	always_comb begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		if (state_reg.out_valid && link.lane_ready) begin
			state_next.out_valid = 1'b0;
		end
		unique case (state_reg.state)
			st_idle: begin
				if (link.link_enable && fifo_valid) begin
					state_next.slots = mapped;
					state_next.frame_sync = sync_calc;
					state_next.frame_kind = hdr_kind;
					state_next.lane_cnt = 4'h0;
					state_next.state = st_emit;
				end
			end
			st_emit: begin
				if (!state_reg.out_valid || link.lane_ready) begin
					state_next.out_valid = 1'b1;
					state_next.out_data = state_reg.slots;
					state_next.out_index = state_reg.lane_cnt;
					state_next.out_tail = tail_needed && (state_reg.lane_cnt == lanes - 4'h1);
					state_next.out_kind = state_reg.frame_kind;
					state_next.out_sync = state_reg.frame_sync;
					if (state_reg.lane_cnt >= lanes - 4'h1) begin
						state_next.state = st_idle;
					end else begin
						state_next.lane_cnt = state_reg.lane_cnt + 4'h1;
					end
				end
			end
		endcase
		// dropping the link abandons the frame in flight
		if (!link.link_enable) begin
			state_next.state = st_idle;
			state_next.out_valid = 1'b0;
		end
		// register port: one acknowledge per request, the cycle after it is seen
		if (link.reg_req && !state_reg.ack) begin
			state_next.ack = 1'b1;
			state_next.rdata = '0;
			if (link.reg_write) begin
				if (link.reg_addr == CHAN_EN_ADDR) begin
					state_next.chan_en = link.reg_wdata[2:0];
				end else if (link.reg_addr == SYNC_SEL_ADDR) begin
					state_next.sync_sel = link.reg_wdata[1:0];
				end
			end else if (link.reg_addr == CHAN_EN_ADDR) begin
				state_next.rdata = {5'h0, state_reg.chan_en};
			end else if (link.reg_addr == SYNC_SEL_ADDR) begin
				state_next.rdata = {6'h0, state_reg.sync_sel};
			end else if (link.reg_addr == LANE_INFO_ADDR) begin
				state_next.rdata = {1'b0, converters, lanes};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.chan_en <= CHAN_EN_RESET;
			state_reg.sync_sel <= SYNC_SEL_RESET;
			state_reg.state <= st_idle;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign link.reg_ack = state_reg.ack;
	assign link.reg_rdata = state_reg.rdata;
	assign link.lane_valid = state_reg.out_valid;
	assign link.lane_data = state_reg.out_data;
	assign link.lane_index = state_reg.out_index;
	assign link.lane_tail = state_reg.out_tail;
	assign link.header_kind = state_reg.out_kind;
	assign link.sync_word = state_reg.out_sync;
endmodule : jesd_cfg_device

// file: design/jesd_cfg_controller.sv
// Purpose: APB-facing controller that configures the transmitter and collects its lane words
// Assumes: APB master holds the request until pready
// Notes: unsafe configuration writes are refused with pslverr and a sticky flag
`timescale 1ns/1ps
module jesd_cfg_controller (
	input wire logic mclk,
	input wire logic reset_n,
	jesd_cfg_if.controller link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [jesd_cfg_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import jesd_cfg_pkg::*;

	typedef enum logic [1:0] {
		c_idle = 2'b00,
		c_wait = 2'b01,
		c_done = 2'b11
	} ctl_state_e;

	typedef struct packed {
		ctl_state_e state;
		logic link_en;
		logic cal_en;
		mode_t mode;
		logic refused;
		logic req;
		logic req_write;
		logic [DEV_ADDR_W-1:0] req_addr;
		logic [DEV_DATA_W-1:0] req_wdata;
		logic [31:0] rdata;
		logic err;
		logic cap_valid;
		logic [SLOT_W-1:0] cap_data;
		logic [3:0] cap_index;
		logic cap_tail;
		logic [1:0] cap_kind;
		logic [SYNC_WORD_W-1:0] cap_sync;
	} ctl_state_s;

	ctl_state_s state_reg;
	ctl_state_s state_next;

	function automatic logic [DEV_ADDR_W-1:0] dev_addr(input logic [APB_ADDR_W-1:0] a);
		dev_addr = (a == CHAN_OFS) ? CHAN_EN_ADDR : (a == SYNC_OFS) ? SYNC_SEL_ADDR :
			LANE_INFO_ADDR;
	endfunction : dev_addr

	logic setup;
	logic done;
	logic [2:0] chan_val;
	logic refuse;
	logic to_dev;

	assign setup = psel && !penable && (state_reg.state == c_idle);
	assign done = psel && penable && (state_reg.state == c_done);
	always_comb begin
		chan_val = pwdata[2:0];
		if (chan_val[SINGLE_BIT]) begin
			chan_val[LOWER_BIT] = 1'b1;
		end
	end

	always_comb begin
		refuse = 1'b0;
		to_dev = 1'b0;
		if (pwrite && paddr == CHAN_OFS) begin
			refuse = state_reg.link_en || state_reg.cal_en || (chan_val[1:0] == 2'h0);
			to_dev = 1'b1;
		end else if (pwrite && paddr == SYNC_OFS) begin
			refuse = state_reg.link_en || pwdata[0];
			to_dev = 1'b1;
		end else if (!pwrite && (paddr == CHAN_OFS || paddr == SYNC_OFS || paddr == INFO_OFS)) begin
			to_dev = 1'b1;
		end
	end

	always_comb begin
		state_next = state_reg;
		if (link.lane_valid && !state_reg.cap_valid) begin
			state_next.cap_valid = 1'b1;
			state_next.cap_data = link.lane_data;
			state_next.cap_index = link.lane_index;
			state_next.cap_tail = link.lane_tail;
			state_next.cap_kind = link.header_kind;
			state_next.cap_sync = link.sync_word;
		end
		unique case (state_reg.state)
			c_idle: begin
				if (setup) begin
					state_next.rdata = '0;
					state_next.err = 1'b0;
					if (to_dev && !refuse) begin
						state_next.req = 1'b1;
						state_next.req_write = pwrite;
						state_next.req_addr = dev_addr(paddr);
						// reserved bits always go out as zero
						state_next.req_wdata = (paddr == CHAN_OFS) ? {5'h0, chan_val} :
							{6'h0, pwdata[1:0]};
						state_next.state = c_wait;
					end else begin
						state_next.state = c_done;
						state_next.err = refuse;
						if (refuse) begin
							state_next.refused = 1'b1;
						end
						unique case (paddr)
							CTRL_OFS: state_next.rdata = {24'h0, state_reg.mode, 2'h0,
								state_reg.cal_en, state_reg.link_en};
							STATUS_OFS: state_next.rdata = {30'h0, state_reg.refused,
								state_reg.cap_valid};
							LANE_LO_OFS: state_next.rdata = state_reg.cap_data[31:0];
							LANE_HI_OFS: state_next.rdata = {state_reg.cap_valid, 20'h0,
								state_reg.cap_kind, state_reg.cap_tail, state_reg.cap_index,
								state_reg.cap_data[SLOT_W-1:32]};
							SYNC_WORD_OFS: state_next.rdata = state_reg.cap_sync;
							INFO_OFS: state_next.rdata = '0;
							default: state_next.err = 1'b1;
						endcase
					end
				end
			end
			c_wait: begin
				if (link.reg_ack) begin
					state_next.req = 1'b0;
					state_next.rdata = {24'h0, link.reg_rdata};
					state_next.state = c_done;
				end
			end
			c_done: begin
				if (done) begin
					state_next.state = c_idle;
					if (pwrite && !state_reg.err && paddr == CTRL_OFS) begin
						state_next.link_en = pwdata[LINK_EN_BIT];
						state_next.cal_en = pwdata[CAL_EN_BIT];
						state_next.mode = pwdata[MODE_LSB+MODE_W-1:MODE_LSB];
					end
					// write-one clears; a refusal is only raised in setup, never in this cycle
					if (pwrite && paddr == STATUS_OFS && pwdata[REFUSED_BIT]) begin
						state_next.refused = 1'b0;
					end
					if (!pwrite && paddr == LANE_HI_OFS) begin
						state_next.cap_valid = 1'b0;
					end
				end
			end
			default: state_next.state = c_idle;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.state <= c_idle;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pready = (state_reg.state == c_done);
	assign pslverr = (state_reg.state == c_done) && state_reg.err;
	assign prdata = state_reg.rdata;
	assign link.reg_req = state_reg.req;
	assign link.reg_write = state_reg.req_write;
	assign link.reg_addr = state_reg.req_addr;
	assign link.reg_wdata = state_reg.req_wdata;
	assign link.link_enable = state_reg.link_en;
	assign link.calib_enable = state_reg.cal_en;
	assign link.link_mode_select = state_reg.mode;
	assign link.lane_ready = !state_reg.cap_valid;
endmodule : jesd_cfg_controller

// file: dv/jesd_cfg_properties.sv
// Purpose: concurrent checks on the link between transmitter and controller
// Assumes: a device register write lands at the edge that takes the request
// Notes: device registers are shadowed from register-port traffic
`timescale 1ns/1ps
module jesd_cfg_properties (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic reg_req,
	input wire logic reg_write,
	input wire logic [jesd_cfg_pkg::DEV_ADDR_W-1:0] reg_addr,
	input wire logic [jesd_cfg_pkg::DEV_DATA_W-1:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic link_enable,
	input wire jesd_cfg_pkg::mode_t link_mode_select,
	input wire logic lane_valid,
	input wire logic [jesd_cfg_pkg::SLOT_W-1:0] lane_data,
	input wire logic [3:0] lane_index,
	input wire logic lane_tail,
	input wire logic [1:0] header_kind,
	input wire logic [jesd_cfg_pkg::SYNC_WORD_W-1:0] sync_word
);
	import jesd_cfg_pkg::*;
	logic [2:0] chan_reg;
	logic [1:0] sync_reg;
	logic [3:0] full_lanes;
	logic [3:0] lanes;
	logic pair_off;
	logic out;
	assign full_lanes = {1'b0, link_mode_select[2:0]} + 4'h1;
	assign pair_off = chan_reg[SINGLE_BIT] || chan_reg[1:0] != 2'h3;
	assign lanes = pair_off ? (full_lanes + 4'h1) >> 1 : full_lanes;
	// words seen while the link drops are aborted, so they are not judged
	assign out = lane_valid && link_enable;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			chan_reg <= CHAN_EN_RESET;
			sync_reg <= SYNC_SEL_RESET;
		end else if (reg_req && reg_write && !reg_ack) begin
			if (reg_addr == CHAN_EN_ADDR) begin
				chan_reg <= reg_wdata[2:0];
			end
			if (reg_addr == SYNC_SEL_ADDR) begin
				sync_reg <= reg_wdata[1:0];
			end
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	sequence ack_pulse;
		reg_ack ##1 !reg_ack;
	endsequence
	a_ack_one_pulse: assert property (reg_req && !reg_ack |=> ack_pulse)
		else $error("register acknowledge not one pulse");
	a_lane_count_bound: assert property (out |-> lane_index < lanes)
		else $error("lane index beyond active lanes");
	a_tail_place: assert property (out |-> lane_tail == (pair_off && full_lanes[0] && lane_index == lanes - 4'h1))
		else $error("tail flag misplaced");
	a_single_slots: assert property (out && chan_reg[SINGLE_BIT] |-> lane_data[SLOT_W-1:SAMPLE_W] == '0)
		else $error("single mode carries other channels");
	a_upper_pair_off: assert property (out && !chan_reg[UPPER_BIT] |-> lane_data[SLOT_W-1:2*SAMPLE_W] == '0)
		else $error("upper slots busy with pair off");
	a_header_select: assert property (out && link_mode_select[MODE_ENC66_BIT] |-> header_kind == (sync_reg == SYNC_FEC ? HDR_FEC : HDR_CRC))
		else $error("header kind differs from selection");
	a_header_enc66: assert property (out && !link_mode_select[MODE_ENC66_BIT] |-> header_kind == HDR_NONE && sync_word == '0)
		else $error("sync word outside 64b66b mode");
	a_command_zero: assert property (out && header_kind != HDR_NONE |-> (header_kind == HDR_CRC ? sync_word[31:12] == 20'h0 : sync_word[31:26] == 6'h0))
		else $error("command bits of sync word not zero");
endmodule : jesd_cfg_properties

// file: dv/jesd_channel_and_sync_header_cfg_bench.sv
// Purpose: self-checking bench for the transmitter and its controller
// Assumes: controller answers within twenty cycles
// Notes: lane words are collected through the controller capture registers
`timescale 1ns/1ps
module jesd_channel_and_sync_header_cfg_bench;
	import jesd_cfg_pkg::*;
	localparam logic [35:0] SMP = {9'h0d4, 9'h0c3, 9'h0b2, 9'h0a1};
	localparam logic [7:0] CH [5] = '{8'h3, 8'h1, 8'h2, 8'h4, 8'h3};
	localparam logic [7:0] SY [5] = '{8'h0, 8'h2, 8'h0, 8'h2, 8'h0};
	localparam logic [3:0] MD [5] = '{4'ha, 4'ha, 4'ha, 4'ha, 4'h3};
	localparam logic [3:0] PW [5] = '{4'hf, 4'h3, 4'hc, 4'h1, 4'hf};
	localparam logic [3:0] LN [5] = '{4'h3, 4'h2, 4'h2, 4'h2, 4'h4};
	localparam logic [2:0] CV [5] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h4};
	localparam logic [1:0] HK [5] = '{HDR_CRC, HDR_FEC, HDR_CRC, HDR_FEC, HDR_NONE};
	localparam logic [35:0] DT [5] = '{SMP, {18'h0, SMP[17:0]}, {18'h0, SMP[35:18]},
		{27'h0, SMP[8:0]}, SMP};
	logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, er;
	logic sample_valid, sample_ready;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [35:0] sample_data, d;
	logic [3:0] channel_power, lanes_active;
	logic [2:0] converters_active;
	int err_total, total_checks, n;
	jesd_cfg_if link();
	jesd_cfg_device u_jesd_cfg_device (.mclk(mclk), .reset_n(reset_n), .link(link),
		.sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
		.channel_power(channel_power), .lanes_active(lanes_active),
		.converters_active(converters_active));
	jesd_cfg_controller u_jesd_cfg_controller (.mclk(mclk), .reset_n(reset_n), .link(link),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	jesd_cfg_properties u_jesd_cfg_properties (.mclk(mclk), .reset_n(reset_n),
		.reg_req(link.reg_req), .reg_write(link.reg_write), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack), .link_enable(link.link_enable),
		.link_mode_select(link.link_mode_select), .lane_valid(link.lane_valid),
		.lane_data(link.lane_data), .lane_index(link.lane_index), .lane_tail(link.lane_tail),
		.header_kind(link.header_kind), .sync_word(link.sync_word));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic print_verdict();
		if (err_total == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int w;
		w = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			w++;
		end while (pready !== 1'b1 && w < 20);
		if (pready !== 1'b1) begin
			err_total++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// a word is read only once captured, else the low half could be stale
	task automatic get_word();
		n = 0;
		do begin
			apb(1'b0, STATUS_OFS, 32'h0);
			n++;
		end while (rd[CAP_BIT] !== 1'b1 && n < 20);
		if (rd[CAP_BIT] !== 1'b1) begin
			err_total++;
			print_verdict();
		end
		apb(1'b0, LANE_LO_OFS, 32'h0);
		d[31:0] = rd;
		apb(1'b0, LANE_HI_OFS, 32'h0);
		d[35:32] = rd[3:0];
	endtask : get_word
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		err_total = 0;
		total_checks = 0;
		reset_n = 1'b0;
		{psel, penable, pwrite, sample_valid} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		sample_data = 36'h0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, CHAN_OFS, 32'h0);
		chk("chan reset", 36'h3, rd[7:0]);
		chk("power reset", 36'hf, channel_power);
		apb(1'b0, SYNC_OFS, 32'h0);
		chk("sync reset", 36'h0, rd[7:0]);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 36'h1, er);
		apb(1'b1, CTRL_OFS, 32'h1);
		apb(1'b1, CHAN_OFS, 32'h1);
		chk("busy chan error", 36'h1, er);
		apb(1'b1, SYNC_OFS, 32'h2);
		chk("busy sync error", 36'h1, er);
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, SYNC_OFS, 32'h1);
		chk("reserved sync error", 36'h1, er);
		apb(1'b1, CHAN_OFS, 32'h0);
		chk("all off error", 36'h1, er);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("refused flag", 36'h1, rd[REFUSED_BIT]);
		apb(1'b1, STATUS_OFS, 32'h2);
		apb(1'b0, CHAN_OFS, 32'h0);
		chk("chan kept", 36'h3, rd[7:0]);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, CHAN_OFS, {24'h0, CH[i]});
			apb(1'b1, SYNC_OFS, {24'h0, SY[i]});
			apb(1'b1, CTRL_OFS, {24'h0, MD[i], 4'h0});
			apb(1'b0, CHAN_OFS, 32'h0);
			chk("chan readback", CH[i] | {7'h0, CH[i][2]}, rd[7:0]);
			chk("power", PW[i], channel_power);
			chk("lanes", LN[i], lanes_active);
			chk("converters", CV[i], converters_active);
			sample_valid <= 1'b1;
			sample_data <= SMP;
			@(posedge mclk);
			sample_valid <= 1'b0;
			apb(1'b1, CTRL_OFS, {24'h0, MD[i], 4'h1});
			for (int j = 0; j < LN[i]; j++) begin
				get_word();
				chk("lane data", DT[i], d);
				chk("lane index", 36'(j), rd[7:4]);
				chk("lane tail", 36'(PW[i] != 4'hf && j == 32'h1), rd[8]);
				chk("header kind", HK[i], rd[10:9]);
			end
			apb(1'b1, CTRL_OFS, {24'h0, MD[i], 4'h0});
		end
		n = 0;
		sample_valid <= 1'b1;
		sample_data <= 36'h0;
		for (int k = 0; k < 16; k++) begin
			@(posedge mclk);
			if (sample_ready === 1'b1) begin
				n++;
				sample_data <= 36'(n);
			end
		end
		sample_valid <= 1'b0;
		chk("fifo fill", 36'h8, 36'(n));
		chk("full ready", 36'h0, sample_ready);
		apb(1'b1, CTRL_OFS, 32'h1);
		for (int k = 0; k < 8; k++) begin
			get_word();
			chk("drain data", 36'(k), d);
		end
		chk("empty ready", 36'h1, sample_ready);
		print_verdict();
	end
endmodule : jesd_channel_and_sync_header_cfg_bench
